// File: src/sdr_pkg.sv
// Package for the segment display memory and backplane scanner.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
package sdr_pkg;
    localparam int          NUM_FP        = 40;
    localparam int          NUM_BP        = 32;
    localparam int          NUM_BANK      = 4;
    localparam int          RAM_BYTES     = 160;
    localparam logic [15:0] WIN_BASE      = 16'h0e00;
    localparam logic [15:0] WIN_LAST      = 16'h0fff;
    localparam logic [15:0] BANK_STRIDE   = 16'h0080;
    localparam logic [6:0]  BANK_LIMIT    = 7'h28;
    localparam int          BANK_POS      = 7;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          FRAME_HZ_DEF  = 64;
    localparam int          SLOTS_PER_FRM = 64;
    localparam logic [7:0]  CONTRAST_RST  = 8'h80;
    localparam logic        DISP_ON_RST   = 1'b0;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sdr_bus_req_t;

    typedef struct packed {
        logic        hit;
        logic [7:0]  rdata;
    } sdr_bus_rsp_t;

    typedef struct packed {
        logic              active;
        logic              field2;
        logic [NUM_BP-1:0] bp_sel;
        logic [NUM_FP-1:0] fp_on;
    } sdr_drive_t;

    typedef enum logic [1:0] {
        SDR_IDLE = 2'b01,
        SDR_SCAN = 2'b10
    } sdr_state_t;
endpackage

// File: src/sdr_scan.sv
// Display memory with processor port and backplane scan logic.
// Assumes bus requests synchronous to clock; analog drivers are outside.
`timescale 1ns/1ps
// Operation
// RULE1 - 160-byte display memory at 0x0E00-0x0FFF
// RULE2 - Stored one turns segment on
// RULE3 - Processor port independent of scan fetch
// RULE4 - Processor reads return stored contents
// RULE5 - Display off: memory is plain RAM
// RULE6 - No reset clears display memory
// RULE7 - Software loads data before enabling display
// RULE8 - Software zeroes unused frontplane bytes
// RULE9 - 40 frontplanes, 32 backplanes driven
// RULE10 - Four banks, byte per frontplane, bit per backplane
// RULE11 - Bank gaps are reserved holes
// RULE12 - Frame clock from programmed divider, sequential selects
// RULE13 - 8-bit contrast setting accepted
// RULE14 - Reset clears display-on, drivers disabled
// RULE15 - Two opposite-polarity fields per frame
// RULE16 - Each backplane active 1/64 frame; code selects each backplane in two slots of the 64-slot frame
// RULE17 - Wait mode keeps display running
// RULE18 - Active slot fetches bits for all frontplanes
module sdr_scan
    import sdr_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Processor bus port
    input  wire sdr_bus_req_t bus_req,
    output sdr_bus_rsp_t      bus_rsp,
    // Control inputs
    input  wire logic         display_drivers_on,
    input  wire logic [15:0]  slot_div,
    input  wire logic [7:0]   contrast_in,
    input  wire logic         wait_mode,
    // Driver outputs
    output sdr_drive_t        drive,
    output logic [7:0]        contrast_level
);
    logic [7:0]        mem [RAM_BYTES];
    logic              on_ff, nxt_on;
    sdr_state_t        st_ff, nxt_st;
    logic [15:0]       div_ff, nxt_div;
    logic [4:0]        bp_ff, nxt_bp;
    logic              fld_ff, nxt_fld;
    logic              tick;
    sdr_bus_rsp_t      rsp_ff, nxt_rsp;
    sdr_drive_t        drv_ff, nxt_drv;
    logic [7:0]        con_ff, nxt_con;
    logic              hit;
    logic [7:0]        idx;
    logic [15:0]       off;

    // Address decode: bank in bits 8:7, frontplane in bits 6:0
    always_comb
    begin
        off = bus_req.addr - WIN_BASE;
        hit = bus_req.sel && bus_req.addr >= WIN_BASE          // [RULE1]
              && bus_req.addr <= WIN_LAST
              && off[6:0] < BANK_LIMIT;                        // [RULE11]
        idx = 8'(off[8:7] * NUM_FP + off[6:0]);                // [RULE10]
    end

    // Processor write port; no reset on contents [RULE6]
    always_ff @(posedge clock)
    begin
        if (hit && bus_req.wr)                                 // [RULE3] [RULE5]
            mem[idx] <= bus_req.wdata;
    end

    // Read data answer
    always_comb
    begin
        nxt_rsp.hit   = hit && !bus_req.wr;
        nxt_rsp.rdata = (hit && !bus_req.wr) ? mem[idx] : 8'h00;  // [RULE4]
    end

    // Slot timing
    always_comb
    begin
        tick    = (div_ff == 16'h0000);
        nxt_on  = display_drivers_on;                          // [RULE17]
        nxt_st  = st_ff;
        nxt_div = div_ff;
        nxt_bp  = bp_ff;
        nxt_fld = fld_ff;
        case (st_ff)
            SDR_IDLE:
            begin
                nxt_div = slot_div;
                nxt_bp  = 5'd0;
                nxt_fld = 1'b0;
                if (on_ff)
                    nxt_st = SDR_SCAN;
            end
            SDR_SCAN:
            begin
                nxt_div = tick ? slot_div : div_ff - 16'h0001; // [RULE12]
                if (tick)
                begin
                    nxt_bp = bp_ff + 5'd1;                     // [RULE12]
                    if (bp_ff == 5'(NUM_BP - 1))
                        nxt_fld = ~fld_ff;                     // [RULE15]
                end
                if (!on_ff)
                    nxt_st = SDR_IDLE;
            end
            default:
                nxt_st = SDR_IDLE;
        endcase
    end

    // Driver image for the active slot
    always_comb
    begin
        nxt_drv        = '0;
        nxt_con        = contrast_in;                          // [RULE13]
        if (st_ff == SDR_SCAN && on_ff)                        // [RULE14]
        begin
            nxt_drv.active = 1'b1;
            nxt_drv.field2 = fld_ff;
            nxt_drv.bp_sel = 32'h1 << bp_ff;                   // [RULE9] [RULE16]
            for (int f = 0; f < NUM_FP; f++)                   // [RULE18]
                nxt_drv.fp_on[f] =
                    mem[8'(bp_ff[4:3] * NUM_FP + f)][bp_ff[2:0]]; // [RULE2]
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            on_ff  <= DISP_ON_RST;                             // [RULE14]
            st_ff  <= SDR_IDLE;
            div_ff <= 16'h0000;
            bp_ff  <= 5'd0;
            fld_ff <= 1'b0;
            rsp_ff <= '0;
            drv_ff <= '0;
            con_ff <= CONTRAST_RST;
        end
        else
        begin
            on_ff  <= nxt_on;
            st_ff  <= nxt_st;
            div_ff <= nxt_div;
            bp_ff  <= nxt_bp;
            fld_ff <= nxt_fld;
            rsp_ff <= nxt_rsp;
            drv_ff <= nxt_drv;
            con_ff <= nxt_con;
        end
    end

    assign bus_rsp        = rsp_ff;
    assign drive          = drv_ff;
    assign contrast_level = con_ff;

    // Checks
    property p_off_idle;
        @(posedge clock) disable iff (!rst_n)
        !on_ff |=> !drive.active;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("drive while off"); // [RULE14]

    property p_onehot;
        @(posedge clock) disable iff (!rst_n)
        drive.active |-> $onehot(drive.bp_sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot"); // [RULE9]

    property p_step;
        @(posedge clock) disable iff (!rst_n)
        (st_ff == SDR_SCAN && on_ff && tick && display_drivers_on)
        |=> bp_ff == $past(bp_ff) + 5'd1;
    endproperty
    a_step: assert property (p_step) else $error("no backplane step"); // [RULE12]

    property p_hold;
        @(posedge clock) disable iff (!rst_n)
        (st_ff == SDR_SCAN && !tick) |=> bp_ff == $past(bp_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("slot too short"); // [RULE16]

    property p_field;
        @(posedge clock) disable iff (!rst_n)
        (st_ff == SDR_SCAN && tick && bp_ff == 5'd31)
        |=> fld_ff != $past(fld_ff);
    endproperty
    a_field: assert property (p_field) else $error("field not flipped"); // [RULE15]

    property p_hole;
        @(posedge clock) disable iff (!rst_n)
        (bus_req.sel && off[6:0] >= BANK_LIMIT) |=> !bus_rsp.hit;
    endproperty
    a_hole: assert property (p_hole) else $error("hole answered"); // [RULE11]

    property p_read;
        @(posedge clock) disable iff (!rst_n)
        (hit && !bus_req.wr) |=> bus_rsp.hit;
    endproperty
    a_read: assert property (p_read) else $error("read not answered"); // [RULE4]

    property p_wait;
        @(posedge clock) disable iff (!rst_n)
        (wait_mode && on_ff && st_ff == SDR_SCAN && display_drivers_on)
        |=> ##1 drive.active;
    endproperty
    a_wait: assert property (p_wait) else $error("wait stopped scan"); // [RULE17]

    property p_contrast;
        @(posedge clock) disable iff (!rst_n)
        rst_n |=> contrast_level == $past(contrast_in);
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast lost"); // [RULE13]

    c_scan:  cover property (@(posedge clock) drive.active && drive.field2);
    c_write: cover property (@(posedge clock) hit && bus_req.wr);
    c_read:  cover property (@(posedge clock) bus_rsp.hit);
endmodule

// File: tb/sdr_panel.sv
// Glass panel model: records each driven backplane slot and its length.
// Assumes drive outputs registered on the rising clock edge.
`timescale 1ns/1ps
module sdr_panel
    import sdr_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Scan side
    input  wire sdr_drive_t drive,
    // Observed slot
    output logic            seen,
    output sdr_drive_t      slot,
    output logic [15:0]     len
);
    sdr_drive_t  cur = '0;
    logic [15:0] cnt = '0;
    always @(posedge clock)
    begin
        seen <= cur.active && (drive.bp_sel !== cur.bp_sel || !drive.active);
        slot <= cur;
        len  <= cnt;
        cnt  <= (drive.bp_sel !== cur.bp_sel) ? 16'h1 : cnt + 16'h1;
        cur  <= drive;
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the display memory and backplane scanner.
// Assumes a 10 MHz clock and the glass panel model on the drive outputs.
`timescale 1ns/1ps
module testbench;
    import sdr_pkg::*;
    logic         clock, rst_n, don, wmode, seen;
    sdr_bus_req_t req;
    sdr_bus_rsp_t rsp;
    logic [15:0]  sdiv, len;
    logic [7:0]   cin, clev, mem [RAM_BYTES];
    sdr_drive_t   drive, slot, ex;
    logic [7:0]   rq [$];
    sdr_drive_t   sq [$];
    int           n_errors, checks_done;

    sdr_scan dut (.clock(clock), .rst_n(rst_n), .bus_req(req),
        .bus_rsp(rsp), .display_drivers_on(don), .slot_div(sdiv),
        .contrast_in(cin), .wait_mode(wmode), .drive(drive),
        .contrast_level(clev));
    sdr_panel panel (.clock(clock), .drive(drive), .seen(seen),
        .slot(slot), .len(len));

    task automatic check(string what, logic [79:0] e, logic [79:0] s);
        checks_done++;
        if (e !== s)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic int idx(logic [15:0] a);
        if (a < WIN_BASE || a > WIN_LAST || a[6:0] >= BANK_LIMIT) return -1;
        return int'((a - WIN_BASE) >> BANK_POS) * NUM_FP + int'(a[6:0]);
    endfunction
    task automatic bus(logic wr, logic [15:0] a, logic [7:0] d);
        int i;
        i = idx(a);
        if (wr && i >= 0) mem[i] = d;
        if (!wr && i >= 0) rq.push_back(mem[i]);
        @(posedge clock);
        req <= '{1'b1, wr, a, d};
        @(posedge clock);
        req <= '0;
        #1;
        if (!wr && i < 0) check("hole read", 9'h0, rsp);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(negedge clock)
    begin
        if (rsp.hit === 1'b1)
            check("rdata", rq.size() ? rq.pop_front() : 9'h1ff, rsp.rdata);
        if (seen === 1'b1 && sq.size() > 0)
        begin
            check("slot", sq.pop_front(), slot);
            check("slot length", sdiv + 17'h1, len);
        end
    end
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        don = 1'b0;
        wmode = 1'b0;
        sdiv = 16'h3;
        cin = 8'h00;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(55));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("drive at reset", 74'h0, drive);
        check("contrast at reset", CONTRAST_RST, clev);
        for (int b = 0; b < NUM_BANK; b++)
            for (int f = 0; f < NUM_FP; f++)
                bus(1'b1, WIN_BASE + 16'(b) * BANK_STRIDE + 16'(f),
                    f == NUM_FP - 1 ? 8'h00 : 8'($urandom));
        rq.delete();
        bus(1'b1, 16'h0e28, 8'h5a);
        bus(1'b1, 16'h0fa8, 8'ha5);
        for (int a = 16'h0e00; a < 16'h1000; a += 16'h17)
            bus(1'b0, 16'(a), 8'h00);
        bus(1'b0, 16'h0d00, 8'h00);
        @(posedge clock);
        cin <= 8'($urandom);
        repeat (2) @(posedge clock);
        #1;
        check("contrast", cin, clev);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("contrast after reset", CONTRAST_RST, clev);
        check("drive after reset", 74'h0, drive);
        for (int i = 0; i < 8; i++)
            bus(1'b0, 16'h0f80 + 16'($urandom % 40), 8'h00);
        for (int i = 0; i < SLOTS_PER_FRM; i++)
        begin
            ex = '0;
            ex.active = 1'b1;
            ex.field2 = i >= NUM_BP;
            ex.bp_sel = 32'h1 << (i % NUM_BP);
            for (int f = 0; f < NUM_FP; f++)
                ex.fp_on[f] = mem[(i % NUM_BP) / 8 * NUM_FP + f][i % 8];
            sq.push_back(ex);
        end
        @(posedge clock);
        wmode <= 1'($urandom);
        don <= 1'b1;
        for (int i = 0; i < 400 && sq.size() > 0; i++) @(posedge clock);
        check("slots left", 0, sq.size());
        don <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("active after off", 1'b0, drive.active);
        conclude();
    end
endmodule
